//--- rtl/fadc_pkg.sv
// Constants and types of the sample capture path.
// Assumes one 40 MHz clock and an AXI4-Lite master with 32-bit data.
package fadc_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int DATA_W = 8;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int RAM_AW = 15;
    localparam int RAM_DEPTH = 32768;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_W = DATA_W + 2;
    localparam int SYNC_CLK = DATA_W;
    localparam int SYNC_BKT = DATA_W + 1;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [AXI_AW-1:0] CTRL_OFS = 8'h00;
    localparam logic [AXI_AW-1:0] STATUS_OFS = 8'h04;
    localparam logic [AXI_AW-1:0] RD_ADDR_OFS = 8'h08;
    localparam logic [AXI_AW-1:0] RD_DATA_OFS = 8'h0c;
    localparam logic [AXI_AW-1:0] WR_ADDR_OFS = 8'h10;

    // ****************************************
    // Control word layout and reset
    // ****************************************
    typedef struct packed {
        logic mem_write_n;
        logic gain_double_select;
        logic pit_select;
        logic sample_mode_n;
        logic full_rate_select;
        logic capture_en;
    } ctrl_t;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h24;

    // ****************************************
    // Status word layout
    // ****************************************
    localparam int ST_GREATER = 0;
    localparam int ST_LESS = 1;
    localparam int ST_OVERFLOW = 2;
    localparam int ST_FIFO_EMPTY = 3;
    localparam int ST_CAPTURE = 4;
    localparam int ST_HELD_LSB = 8;

    // ****************************************
    // Bus responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fadc_pkg

//--- rtl/fast_adc_peak_pit_detector.sv
// Sample FIFO and the peak, pit and sample hold path with its sample RAM.
// Assumes converter data and clocks arrive from pins
// and software uses AXI4-Lite.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

// ****************************************
// Sample FIFO
// ****************************************
module sample_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != (PW+1)'(D));
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule : sample_fifo

// ****************************************
// Capture path top
// ****************************************
// Behaviour
// - Peak or pit only below full rate
// - Peak mode keeps largest sample per bucket
// - Pit mode keeps smallest sample per bucket
// - Sample mode keeps last sample per bucket
// - Latch loads only while qualifier low
// - Full rate forces qualifier low always
// - Comparator flags greater, less, neither when equal
// - Peak: capture only if incoming exceeds held
// - Pit: capture only if incoming below held
// - Sample mode or bucket clock forces capture
// - Converter gives unsigned bytes at fixed rate
// - Converter codes saturate at zero and 255
// - Capture mode writes held samples to RAM
// - CPU reads RAM only outside capture
// - Hold latch byte feeds RAM data port below full rate; full rate feeds the sample
// - Gain select drives complementary switch enables
// - Capture bit runs clocks, blocks RAM reads
module fast_adc_peak_pit_detector (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [fadc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [fadc_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [fadc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [fadc_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter pins
    input wire logic conv_clk,
    input wire logic [fadc_pkg::DATA_W-1:0] conv_data,
    input wire logic bucket_clk,
    // Analog controls and held byte
    output logic gain_double_en,
    output logic gain_unity_en,
    output logic [fadc_pkg::DATA_W-1:0] held_byte
);
    import fadc_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [SYNC_W-1:0] sync3_ff;
    logic [SYNC_W-1:0] filt_ff;
    logic conv_clk_prev_ff;
    logic [SYNC_W-1:0] agree;
    logic conv_strobe;
    logic [DATA_W-1:0] sample;
    logic bucket;

    // A bit moves once two stages agree
    assign agree = ~(sync2_ff ^ sync3_ff);
    assign sample = filt_ff[DATA_W-1:0];
    assign bucket = filt_ff[SYNC_BKT];
    assign conv_strobe = filt_ff[SYNC_CLK] & ~conv_clk_prev_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            filt_ff <= '0;
            conv_clk_prev_ff <= 1'b0;
        end else begin
            sync1_ff <= {bucket_clk, conv_clk, conv_data};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff <= (sync3_ff & agree) | (filt_ff & ~agree);
            conv_clk_prev_ff <= filt_ff[SYNC_CLK];
        end
    end

    // ****************************************
    // Control state
    // ****************************************
    ctrl_t ctrl_ff;
    logic overflow_ff;
    logic [RAM_AW-1:0] rd_addr_ff;
    logic [RAM_AW-1:0] wr_addr_ff;

    // ****************************************
    // Comparator and qualifier
    // ****************************************
    logic [DATA_W-1:0] hold_ff;
    logic greater;
    logic less;
    logic qual_n;
    logic latch_clock_qualifier_n;
    logic capture_strobe;

    function automatic logic qualifier(input ctrl_t c, input logic bkt, input logic gt,
                                       input logic lt);
        logic q;
        q = 1'b0;
        if (c.full_rate_select) begin
            q = 1'b0;
        end else if (!c.sample_mode_n || bkt) begin
            q = 1'b0;
        end else if (c.pit_select) begin
            q = ~lt;
        end else begin
            q = ~gt;
        end
        return q;
    endfunction : qualifier

    assign greater = (sample > hold_ff);
    assign less = (sample < hold_ff);
    assign qual_n = qualifier(ctrl_ff, bucket, greater, less);
    // Clocks stop unless capturing
    assign capture_strobe = conv_strobe & ctrl_ff.capture_en;

    // ****************************************
    // Hold latch
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_ff <= '0;
        end else if (capture_strobe && !qual_n) begin
            hold_ff <= sample;
        end
    end

    logic incoming_greater_flag_ff;
    logic incoming_less_flag_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_clock_qualifier_n <= 1'b0;
            incoming_greater_flag_ff <= 1'b0;
            incoming_less_flag_ff <= 1'b0;
            held_byte <= '0;
            gain_double_en <= 1'b0;
            gain_unity_en <= 1'b1;
        end else begin
            latch_clock_qualifier_n <= qual_n;
            incoming_greater_flag_ff <= greater;
            incoming_less_flag_ff <= less;
            held_byte <= hold_ff;
            gain_double_en <= ctrl_ff.gain_double_select;
            gain_unity_en <= ~ctrl_ff.gain_double_select;
        end
    end

    // ****************************************
    // Write events into the FIFO
    // ****************************************
    logic pend_ff;
    logic [DATA_W-1:0] pend_data_ff;
    logic write_event;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [DATA_W-1:0] fifo_out_data;

    // Boundary writes the finished bucket first
    assign write_event = capture_strobe & (ctrl_ff.full_rate_select | bucket);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_ff <= 1'b0;
            pend_data_ff <= '0;
        end else if (write_event) begin
            pend_ff <= 1'b1;
            pend_data_ff <= ctrl_ff.full_rate_select ? sample : hold_ff;
        end else if (fifo_in_ready) begin
            pend_ff <= 1'b0;
        end
    end

    // Software may stall RAM writes
    assign fifo_out_ready = ~ctrl_ff.mem_write_n;

    sample_fifo #(
        .W(DATA_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(pend_ff),
        .in_ready(fifo_in_ready),
        .in_data(pend_data_ff),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ****************************************
    // Sample RAM
    // ****************************************
    logic [DATA_W-1:0] sample_ram [RAM_DEPTH];

    always_ff @(posedge aclk) begin
        if (fifo_out_valid && fifo_out_ready) begin
            sample_ram[wr_addr_ff] <= fifo_out_data;
        end
    end

    // Circular write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_addr_ff <= '0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            wr_addr_ff <= wr_addr_ff + 1'b1;
        end
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [AXI_AW-1:0] aw_addr_ff;
    logic [AXI_DW-1:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic do_write;
    logic ovf_clear;
    logic ovf_set;

    assign do_write = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (aw_addr_ff)
                    CTRL_OFS, STATUS_OFS, RD_ADDR_OFS: s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= ctrl_t'(CTRL_RESET);
        end else if (do_write && aw_addr_ff == CTRL_OFS && w_strb_ff[0]) begin
            ctrl_ff <= ctrl_t'(w_data_ff[CTRL_W-1:0]);
        end
    end

    // Overflow: byte lost to a full FIFO; set wins
    assign ovf_set = write_event & pend_ff & ~fifo_in_ready;
    assign ovf_clear = do_write & (aw_addr_ff == STATUS_OFS) & w_strb_ff[0]
                       & w_data_ff[ST_OVERFLOW];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_ff <= 1'b0;
        end else if (ovf_set) begin
            overflow_ff <= 1'b1;
        end else if (ovf_clear) begin
            overflow_ff <= 1'b0;
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    logic ram_read_ok;
    logic ar_take;
    logic [AXI_DW-1:0] status_word;

    // A read mid capture would race the writer
    assign ram_read_ok = ~ctrl_ff.capture_en & ~fifo_out_valid;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    always_comb begin
        status_word = '0;
        status_word[ST_GREATER] = incoming_greater_flag_ff;
        status_word[ST_LESS] = incoming_less_flag_ff;
        status_word[ST_OVERFLOW] = overflow_ff;
        status_word[ST_FIFO_EMPTY] = ~fifo_out_valid;
        status_word[ST_CAPTURE] = ctrl_ff.capture_en;
        status_word[ST_HELD_LSB +: DATA_W] = hold_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= '0;
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr)
                    CTRL_OFS: s_axi_rdata[CTRL_W-1:0] <= ctrl_ff;
                    STATUS_OFS: s_axi_rdata <= status_word;
                    RD_ADDR_OFS: s_axi_rdata[RAM_AW-1:0] <= rd_addr_ff;
                    WR_ADDR_OFS: s_axi_rdata[RAM_AW-1:0] <= wr_addr_ff;
                    RD_DATA_OFS: begin
                        if (ram_read_ok) begin
                            s_axi_rdata[DATA_W-1:0] <= sample_ram[rd_addr_ff];
                        end else begin
                            s_axi_rresp <= RESP_SLVERR;
                        end
                    end
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Steps per granted read; a write wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr_ff <= '0;
        end else if (do_write && aw_addr_ff == RD_ADDR_OFS && w_strb_ff[0]) begin
            rd_addr_ff <= w_data_ff[RAM_AW-1:0];
        end else if (ar_take && s_axi_araddr == RD_DATA_OFS && ram_read_ok) begin
            rd_addr_ff <= rd_addr_ff + 1'b1;
        end
    end

endmodule : fast_adc_peak_pit_detector

//--- verification/fadc_checker.sv
// Checker of bus, held byte and gain.
// Bound to the top; sees only its ports.
`timescale 1ns/100ps
module fadc_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [fadc_pkg::AXI_DW-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic conv_clk,
    input wire logic gain_double_en,
    input wire logic gain_unity_en,
    input wire logic [fadc_pkg::DATA_W-1:0] held_byte
);
    import fadc_pkg::*;
    // ****
    // Cycles since converter clock rise
    // ****
    logic conv_clk_d_ff;
    logic [3:0] since_rise_ff;
    always_ff @(posedge aclk) begin
        conv_clk_d_ff <= conv_clk;
        if (!aresetn) begin
            since_rise_ff <= 4'hf;
        end else if (conv_clk && !conv_clk_d_ff) begin
            since_rise_ff <= 4'h0;
        end else if (since_rise_ff != 4'hf) begin
            since_rise_ff <= since_rise_ff + 4'h1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****
    // Properties
    // ****
    property p_gain_compl; gain_double_en != gain_unity_en; endproperty
    a_gain_compl: assert property (p_gain_compl) else $error("gain enables");
    // A load long after any rise is stray
    property p_held_cause; $changed(held_byte) |-> since_rise_ff <= 4'ha; endproperty
    a_held_cause: assert property (p_held_cause) else $error("stray load");
    property p_b_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stands: assert property (p_b_stands) else $error("b dropped");
    property p_r_stands;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    a_r_stands: assert property (p_r_stands) else $error("r dropped");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("r late");
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("b late");
    property p_b_blocks; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_blocks: assert property (p_b_blocks) else $error("w while b");
    property p_err_zero; s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused data");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid; endproperty
    a_r_done: assert property (p_r_done) else $error("r not freed");
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_held: cover property ($changed(held_byte));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : fadc_checker

bind fast_adc_peak_pit_detector fadc_checker u_chk (.*);

//--- verification/fadc_cpu_model.sv
// Controller CPU model: AXI4-Lite master.
// Assumes one clock; one wr and one rd at a time.
`timescale 1ns/100ps
module fadc_cpu_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [fadc_pkg::AXI_AW-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [fadc_pkg::AXI_DW-1:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels
    output logic [fadc_pkg::AXI_AW-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [fadc_pkg::AXI_DW-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    import fadc_pkg::*;
    initial begin
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end
    // Released payloads inverted
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d,
                      output logic [1:0] r);
        logic done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr
    // Reads any address in any mode
    task automatic rd(input logic [AXI_AW-1:0] a, output logic [AXI_DW-1:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : fadc_cpu_model

//--- verification/fast_adc_peak_pit_detector_bench.sv
// Bench of the capture path.
// Assumes the CPU model and the bound checker.
`timescale 1ns/100ps
module fast_adc_peak_pit_detector_bench;
    import fadc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic conv_clk = 1'b0;
    logic [DATA_W-1:0] conv_data = 8'h00;
    logic bucket_clk = 1'b0;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [AXI_DW-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic gain_double_en, gain_unity_en;
    logic [DATA_W-1:0] held_byte;
    int fails = 0;
    int check_count = 0;
    always #12.5 aclk = ~aclk;
    fast_adc_peak_pit_detector DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_clk(conv_clk),
        .conv_data(conv_data), .bucket_clk(bucket_clk), .gain_double_en(gain_double_en),
        .gain_unity_en(gain_unity_en), .held_byte(held_byte));
    fadc_cpu_model cpu (.aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        cpu.wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        cpu.rd(a, d, r);
        chk(d & m, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rchk
    // Released data inverted
    task automatic smp(input logic [7:0] v, input logic b);
        @(posedge aclk);
        conv_data <= v;
        bucket_clk <= b;
        conv_clk <= 1'b1;
        repeat (3) @(posedge aclk);
        conv_clk <= 1'b0;
        conv_data <= ~v;
        repeat (3) @(posedge aclk);
    endtask : smp
    task automatic wait_empty();
        logic [31:0] d = '0;
        logic [1:0] r;
        for (int i = 0; i < 40 && !d[ST_FIFO_EMPTY]; i++) begin
            cpu.rd(STATUS_OFS, d, r);
        end
    endtask : wait_empty
    // ****
    // Scenarios
    // ****
    task automatic t_reset_gain();
        rchk(CTRL_OFS, 32'hff, 32'h24, RESP_OKAY);
        chk({30'h0, gain_double_en, gain_unity_en}, 32'h1);
        wreg(CTRL_OFS, 32'h34, RESP_OKAY);
        @(negedge aclk);
        chk({30'h0, gain_double_en, gain_unity_en}, 32'h2);
        wreg(CTRL_OFS, 32'h24, RESP_OKAY);
        rchk(8'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
        wreg(WR_ADDR_OFS, 32'h5, RESP_SLVERR);
    endtask : t_reset_gain
    // Buckets 32 5a 5a 14 | 3c 00 ff, then 80
    task automatic run_mode(input logic [5:0] md, input logic [7:0] e1, input logic [7:0] e2);
        logic [7:0] sq [8] = '{8'h32, 8'h5a, 8'h5a, 8'h14, 8'h3c, 8'h00, 8'hff, 8'h80};
        logic [7:0] bk = 8'b1001_0001;
        logic [31:0] a0;
        logic [1:0] r;
        cpu.rd(WR_ADDR_OFS, a0, r);
        wreg(CTRL_OFS, {26'h0, md}, RESP_OKAY);
        rchk(RD_DATA_OFS, 32'hffffffff, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            smp(sq[i], bk[i]);
        end
        wreg(CTRL_OFS, {26'h0, md & 6'h3e}, RESP_OKAY);
        wait_empty();
        rchk(STATUS_OFS, 32'hffff, 32'h800a, RESP_OKAY);
        rchk(WR_ADDR_OFS, 32'h7fff, a0 + (md[1] ? 32'h8 : 32'h3), RESP_OKAY);
        wreg(RD_ADDR_OFS, a0 + {31'h0, !md[1]}, RESP_OKAY);
        for (int k = 0; k < (md[1] ? 8 : 2); k++) begin
            rchk(RD_DATA_OFS, 32'hffffffff, md[1] ? sq[k] : (k == 0 ? e1 : e2), RESP_OKAY);
        end
    endtask : run_mode
    // Stall until FIFO refuses
    task automatic t_fifo();
        logic [31:0] a0;
        logic [1:0] r;
        cpu.rd(WR_ADDR_OFS, a0, r);
        wreg(CTRL_OFS, 32'h23, RESP_OKAY);
        for (int i = 0; i < 18; i++) begin
            smp(8'(i), 1'b0);
        end
        rchk(STATUS_OFS, 32'h1c, 32'h14, RESP_OKAY);
        wreg(CTRL_OFS, 32'h03, RESP_OKAY);
        wreg(CTRL_OFS, 32'h02, RESP_OKAY);
        wait_empty();
        rchk(WR_ADDR_OFS, 32'h7fff, a0 + 32'h11, RESP_OKAY);
        wreg(STATUS_OFS, 32'h4, RESP_OKAY);
        rchk(STATUS_OFS, 32'h1c, 32'h08, RESP_OKAY);
    endtask : t_fifo
    task automatic summarize();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_gain();
        run_mode(6'h05, 8'h5a, 8'hff);
        run_mode(6'h0d, 8'h14, 8'h00);
        run_mode(6'h01, 8'h14, 8'hff);
        run_mode(6'h0f, 8'h00, 8'h00);
        t_fifo();
        summarize();
    end
    // Whole run is under a thousand cycles
    initial begin
        repeat (40000) @(posedge aclk);
        fails++;
        summarize();
    end
endmodule : fast_adc_peak_pit_detector_bench
